/* File: smel_pkg.sv */
package smel_pkg;

    // task-file bytes in snapshot order; the last byte is command or status
    typedef struct packed {
        logic [7:0] devctl;
        logic [7:0] feat_err;
        logic [7:0] sec_cnt;
        logic [7:0] sec_num;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] dev_head;
        logic [7:0] cmd_stat;
    } smel_tf_t;

    typedef struct packed {
        smel_tf_t tf;
        logic [31:0] ts;
    } smel_cmd_snap_t;

    typedef enum logic [3:0] {
        SMEL_ST_UNKNOWN = 4'h0,
        SMEL_ST_SLEEP = 4'h1,
        SMEL_ST_STANDBY = 4'h2,
        SMEL_ST_ACTIVE = 4'h3,
        SMEL_ST_SELFTEST = 4'h4
    } smel_dev_state_t;

    typedef struct packed {
        smel_cmd_snap_t snap;
        logic [7:0] state;
    } smel_hist_t;

    typedef struct packed {
        smel_cmd_snap_t [4:0] cmds;
        smel_tf_t tf;
        logic [7:0] state;
        logic [15:0] poh;
    } smel_err_rec_t;

    typedef enum logic [0:0] {
        SMEL_RD_IDLE = 1'h0,
        SMEL_RD_STREAM = 1'h1
    } smel_rd_state_t;

    localparam logic [7:0] ERR_VERSION = 8'h01;
    localparam logic [15:0] ST_REVISION = 16'h0001;
    localparam logic [8:0] SECT_LAST = 9'h1FF;
    localparam logic [8:0] ERR_IDX_ADDR = 9'h001;
    localparam logic [8:0] ERR_ENT_BASE = 9'h002;
    localparam logic [8:0] ERR_ENT_LEN = 9'h05A;
    localparam logic [8:0] ERR_ENT_END = 9'h1C4;
    localparam logic [8:0] ERR_CNT_LO = 9'h1C4;
    localparam logic [8:0] ERR_CNT_HI = 9'h1C5;
    localparam logic [6:0] CMD_SNAP_LEN = 7'h0C;
    localparam logic [6:0] ERR_SNAP_OFS = 7'h3C;
    localparam logic [4:0] ERR_TF_LEN = 5'h08;
    localparam logic [4:0] ERR_STATE_OFS = 5'h1B;
    localparam logic [4:0] ERR_POH_LO = 5'h1C;
    localparam logic [4:0] ERR_POH_HI = 5'h1D;
    localparam logic [2:0] NUM_ENTRIES = 3'h5;
    localparam logic [2:0] HIST_DEPTH = 3'h5;
    localparam logic [8:0] ST_REV_LO = 9'h000;
    localparam logic [8:0] ST_REV_HI = 9'h001;
    localparam logic [8:0] ST_INDEX_ADDR = 9'h1FC;
    localparam logic [4:0] ST_NUM_DESC = 5'h15;
    localparam logic [15:0] ERR_CNT_MAX = 16'hFFFF;
    localparam logic [3:0] STATE_HI_NIBBLE = 4'h0;
    localparam logic HIST_KEEP = 1'b1;
    localparam logic [2:0] ERR_IDX_RST = 3'h0;
    localparam logic [4:0] ST_IDX_RST = 5'h00;
    localparam logic [15:0] ERR_CNT_RST = 16'h0000;
    localparam logic [8:0] RD_CNT_RST = 9'h000;

endpackage

/* File: smel_sum8.sv */
`timescale 1ns/1ps
`default_nettype none

// running modulo-256 sum of the bytes streamed so far
module smel_sum8 (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clr_in,
    input wire logic add_in,
    input wire logic [7:0] byte_in,
    output logic [7:0] sum_out
);

    logic [7:0] sum_r;

    always_ff @(posedge clk_in) begin
        if (rst_in || clr_in) begin
            sum_r <= 8'h00;
        end else if (add_in) begin
            sum_r <= sum_r + byte_in;
        end
    end

    assign sum_out = sum_r;

endmodule // smel_sum8

`default_nettype wire

/* File: smel_log_builder.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - only the five latest errors are kept, overwriting entries circularly.
// - the error log index names the most recently written entry.
// - entries never written read as all zero bytes.
// - entry holds five 12-byte command snapshots then a 30-byte error snapshot.
// - fifth snapshot is the failing command; earlier ones go backwards in time.
// - leading snapshots without a predecessor are zero.
// - when history is not kept, predecessor snapshots are zero.
// - command write captures seven task-file bytes, command byte and timestamp.
// - error completion captures control, error, task-file bytes and status.
// - extended error bytes are implementation choice; here they are zero.
// - state byte is the device state when the failing command was written.
// - state low nibble uses the fixed code set; high nibble is chosen.
// - last two error bytes hold power-on hours, low byte first.
// - device-attributable errors increment the lifetime error count.
// - errors caused by faulty host requests do not increment the count.
// - the error count saturates at its maximum.
// - byte 511 makes the sum of all 512 bytes zero.
// - self-test sector: revision, 21 descriptors, vendor, index, reserved, checksum.
// - error sector: version, index, five entries, count, reserved, checksum.
// - error log version byte reads one.
// - self-test index is zero when empty, counts 1..21, wraps to one.
// - self-test revision number reads one.
module smel_log_builder
    import smel_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_wr_in,
    input wire smel_tf_t cmd_tf_in,
    input wire logic [31:0] ts_in,
    input wire smel_dev_state_t dev_state_in,
    input wire logic err_evt_in,
    input wire smel_tf_t err_tf_in,
    input wire logic err_dev_fault_in,
    input wire logic [15:0] poh_hours_in,
    input wire logic st_entry_in,
    input wire logic rd_req_in,
    input wire logic rd_sel_st_in,
    output logic rd_busy_out,
    output logic rd_valid_out,
    output logic [7:0] rd_data_out,
    output logic [8:0] rd_addr_out,
    output logic rd_last_out,
    output logic [2:0] err_index_out,
    output logic [15:0] err_count_out,
    output logic [4:0] st_index_out
);

    smel_hist_t hist_r [0:4];
    logic [2:0] hist_cnt_r;
    smel_err_rec_t rec_r [0:4];
    logic [2:0] err_idx_r;
    logic [2:0] err_idx_nxt;
    logic [15:0] err_cnt_r;
    logic [4:0] st_idx_r;
    smel_rd_state_t rd_state_r;
    logic [8:0] rd_cnt_r;
    logic rd_sel_st_r;
    logic [7:0] sum_acc;
    logic [7:0] byte_nxt;
    logic stream_en;

    function automatic logic [7:0] tf_byte(input smel_tf_t tf, input logic [3:0] k);
        logic [5:0] sh;
        sh = {3'(3'h7 - k[2:0]), 3'h0};
        return 8'(tf >> sh);
    endfunction

    function automatic logic [7:0] snap_byte(input smel_cmd_snap_t s, input logic [3:0] k);
        logic [4:0] sh;
        sh = {2'(k[1:0]), 3'h0};
        if (k < 4'h8) begin
            return tf_byte(s.tf, k);
        end
        return 8'(s.ts >> sh);
    endfunction

    function automatic logic [7:0] state_code(input smel_dev_state_t st);
        return {STATE_HI_NIBBLE, st};
    endfunction

    // capture snapshot and device state at every command register write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 5; i++) begin
                hist_r[i] <= '0;
            end
        end else if (cmd_wr_in) begin
            hist_r[0] <= '{snap: '{tf: cmd_tf_in, ts: ts_in},
                           state: state_code(dev_state_in)};
            for (int i = 1; i < 5; i++) begin
                hist_r[i] <= hist_r[i - 1];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hist_cnt_r <= 3'h0;
        end else if (cmd_wr_in && hist_cnt_r != HIST_DEPTH) begin
            hist_cnt_r <= hist_cnt_r + 3'h1;
        end
    end

    always_comb begin
        err_idx_nxt = err_idx_r + 3'h1;
        if (err_idx_r == NUM_ENTRIES) begin
            err_idx_nxt = 3'h1;
        end
    end

    // build the entry for the error being reported
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 5; i++) begin
                rec_r[i] <= '0;
            end
        end else if (err_evt_in) begin
            for (int s = 0; s < 5; s++) begin
                if (hist_cnt_r > 3'(4 - s) && (s == 4 || HIST_KEEP)) begin
                    rec_r[err_idx_nxt - 3'h1].cmds[s] <= hist_r[4 - s].snap;
                end else begin
                    rec_r[err_idx_nxt - 3'h1].cmds[s] <= '0;
                end
            end
            rec_r[err_idx_nxt - 3'h1].tf <= err_tf_in;
            rec_r[err_idx_nxt - 3'h1].state <= hist_r[0].state;
            rec_r[err_idx_nxt - 3'h1].poh <= poh_hours_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            err_idx_r <= ERR_IDX_RST;
        end else if (err_evt_in) begin
            err_idx_r <= err_idx_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            err_cnt_r <= ERR_CNT_RST;
        end else if (err_evt_in && err_dev_fault_in && err_cnt_r != ERR_CNT_MAX) begin
            err_cnt_r <= err_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_idx_r <= ST_IDX_RST;
        end else if (st_entry_in) begin
            st_idx_r <= (st_idx_r == ST_NUM_DESC) ? 5'h01 : st_idx_r + 5'h01;
        end
    end

    // byte of the selected sector at the current read address
    always_comb begin
        logic [8:0] off;
        logic [2:0] ent;
        logic [6:0] ofs;
        logic [4:0] eo;
        smel_err_rec_t rec;
        off = rd_cnt_r - ERR_ENT_BASE;
        ent = 3'(off / ERR_ENT_LEN);
        ofs = 7'(off % ERR_ENT_LEN);
        eo = 5'(ofs - ERR_SNAP_OFS);
        rec = rec_r[(ent < NUM_ENTRIES) ? ent : 3'h0];
        byte_nxt = 8'h00;
        if (rd_sel_st_r) begin
            if (rd_cnt_r == ST_REV_LO) begin
                byte_nxt = ST_REVISION[7:0];
            end else if (rd_cnt_r == ST_REV_HI) begin
                byte_nxt = ST_REVISION[15:8];
            end else if (rd_cnt_r == ST_INDEX_ADDR) begin
                byte_nxt = {3'h0, st_idx_r};
            end
        end else if (rd_cnt_r == 9'h000) begin
            byte_nxt = ERR_VERSION;
        end else if (rd_cnt_r == ERR_IDX_ADDR) begin
            byte_nxt = {5'h00, err_idx_r};
        end else if (rd_cnt_r < ERR_ENT_END) begin
            if (ofs < ERR_SNAP_OFS) begin
                byte_nxt = snap_byte(rec.cmds[3'(ofs / CMD_SNAP_LEN)],
                                     4'(ofs % CMD_SNAP_LEN));
            end else if (eo < ERR_TF_LEN) begin
                byte_nxt = tf_byte(rec.tf, eo[3:0]);
            end else if (eo == ERR_STATE_OFS) begin
                byte_nxt = rec.state;
            end else if (eo == ERR_POH_LO) begin
                byte_nxt = rec.poh[7:0];
            end else if (eo == ERR_POH_HI) begin
                byte_nxt = rec.poh[15:8];
            end
        end else if (rd_cnt_r == ERR_CNT_LO) begin
            byte_nxt = err_cnt_r[7:0];
        end else if (rd_cnt_r == ERR_CNT_HI) begin
            byte_nxt = err_cnt_r[15:8];
        end
    end

    assign stream_en = (rd_state_r == SMEL_RD_STREAM);

    smel_sum8 u_sum (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clr_in(rd_state_r == SMEL_RD_IDLE),
        .add_in(stream_en),
        .byte_in(byte_nxt),
        .sum_out(sum_acc)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_state_r <= SMEL_RD_IDLE;
            rd_cnt_r <= RD_CNT_RST;
            rd_sel_st_r <= 1'b0;
        end else begin
            case (rd_state_r)
                SMEL_RD_IDLE: begin
                    if (rd_req_in) begin
                        rd_state_r <= SMEL_RD_STREAM;
                        rd_cnt_r <= RD_CNT_RST;
                        rd_sel_st_r <= rd_sel_st_in;
                    end
                end
                SMEL_RD_STREAM: begin
                    rd_cnt_r <= rd_cnt_r + 9'h001;
                    if (rd_cnt_r == SECT_LAST) begin
                        rd_state_r <= SMEL_RD_IDLE;
                    end
                end
                default: begin
                    rd_state_r <= SMEL_RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= 8'h00;
            rd_addr_out <= 9'h000;
            rd_last_out <= 1'b0;
        end else begin
            rd_valid_out <= stream_en;
            rd_last_out <= stream_en && rd_cnt_r == SECT_LAST;
            if (stream_en) begin
                rd_addr_out <= rd_cnt_r;
                rd_data_out <= (rd_cnt_r == SECT_LAST) ? 8'(8'h00 - sum_acc) : byte_nxt;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_busy_out <= 1'b0;
            err_index_out <= ERR_IDX_RST;
            err_count_out <= ERR_CNT_RST;
            st_index_out <= ST_IDX_RST;
        end else begin
            rd_busy_out <= (rd_state_r == SMEL_RD_IDLE) ? rd_req_in : rd_cnt_r != SECT_LAST;
            err_index_out <= err_evt_in ? err_idx_nxt : err_idx_r;
            err_count_out <= err_cnt_r;
            st_index_out <= st_idx_r;
        end
    end

    // checking helpers
    logic [7:0] chk_sum_r;
    logic [2:0] used_r;

    always_ff @(posedge clk_in) begin
        if (rst_in || !rd_valid_out) begin
            chk_sum_r <= 8'h00;
        end else begin
            chk_sum_r <= chk_sum_r + rd_data_out;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            used_r <= 3'h0;
        end else if (err_evt_in && used_r != NUM_ENTRIES) begin
            used_r <= used_r + 3'h1;
        end
    end

    AST_PTR_WRAP: assert property (@(posedge clk_in) disable iff (rst_in)
        err_evt_in && err_idx_r == NUM_ENTRIES |=> err_idx_r == 3'h1)
        else $error("error index did not wrap to one");

    AST_PTR_STEP: assert property (@(posedge clk_in) disable iff (rst_in)
        err_evt_in && err_idx_r < NUM_ENTRIES |=> err_idx_r == $past(err_idx_r) + 3'h1)
        else $error("error index did not advance");

    AST_ZERO_FILL: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_valid_out && !rd_sel_st_r && $stable(used_r) && rd_addr_out < ERR_ENT_END
        && rd_addr_out >= 9'(ERR_ENT_BASE + ERR_ENT_LEN * used_r) |-> rd_data_out == 8'h00)
        else $error("unused error entry not zero");

    AST_CNT_INC: assert property (@(posedge clk_in) disable iff (rst_in)
        err_evt_in && err_dev_fault_in && err_cnt_r != ERR_CNT_MAX
        |=> ##1 err_count_out == $past(err_cnt_r, 2) + 16'h0001)
        else $error("device error count did not increment");

    AST_CNT_HOST: assert property (@(posedge clk_in) disable iff (rst_in)
        err_evt_in && !err_dev_fault_in |=> $stable(err_cnt_r))
        else $error("host-caused error changed the count");

    AST_CNT_SAT: assert property (@(posedge clk_in) disable iff (rst_in)
        err_cnt_r == ERR_CNT_MAX |=> err_cnt_r == ERR_CNT_MAX)
        else $error("error count left saturation");

    AST_CSUM: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_last_out |-> 8'(chk_sum_r + rd_data_out) == 8'h00 && rd_addr_out == SECT_LAST)
        else $error("sector checksum wrong");

    AST_VERSION: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_valid_out && !rd_sel_st_r && rd_addr_out == 9'h000 |-> rd_data_out == ERR_VERSION)
        else $error("error log version not one");

    AST_ST_REV: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_valid_out && rd_sel_st_r && rd_addr_out == ST_REV_LO
        |-> rd_data_out == 8'h01 ##1 rd_data_out == 8'h00)
        else $error("self-test revision not one");

    AST_ST_IDX: assert property (@(posedge clk_in) disable iff (rst_in)
        st_entry_in && st_idx_r == ST_NUM_DESC |=> ##1 st_index_out == 5'h01)
        else $error("self-test index did not wrap");

    AST_RD_START: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_req_in && !rd_busy_out && rd_state_r == SMEL_RD_IDLE
        |=> rd_busy_out ##1 rd_valid_out && rd_addr_out == 9'h000)
        else $error("read did not start two cycles after request");

    CVR_ERR_READ: cover property (@(posedge clk_in) disable iff (rst_in)
        rd_last_out && !rd_sel_st_r && used_r != 3'h0);
    CVR_ST_READ: cover property (@(posedge clk_in) disable iff (rst_in)
        rd_last_out && rd_sel_st_r);
    CVR_WRAP: cover property (@(posedge clk_in) disable iff (rst_in)
        err_evt_in && err_idx_r == NUM_ENTRIES);
    CVR_HOST_ERR: cover property (@(posedge clk_in) disable iff (rst_in)
        err_evt_in && !err_dev_fault_in);

endmodule // smel_log_builder

`default_nettype wire

/* File: smel_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// host side: asks for one sector and keeps the streamed bytes by address
module smel_host_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic sel_in,
    input wire logic rd_busy_in,
    input wire logic rd_valid_in,
    input wire logic [7:0] rd_data_in,
    input wire logic [8:0] rd_addr_in,
    input wire logic rd_last_in,
    output logic rd_req_out,
    output logic rd_sel_out,
    output logic done_out
);
    logic [7:0] mem [512];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_req_out <= 1'b0;
            rd_sel_out <= 1'b0;
            done_out <= 1'b0;
        end else if (go_in) begin
            rd_req_out <= 1'b1;
            rd_sel_out <= sel_in;
            done_out <= 1'b0;
            // unknown fill so a byte that never arrives cannot match
            for (int i = 0; i < 512; i++) begin
                mem[i] <= 8'hXX;
            end
        end else begin
            // hold the request until taken, then invert the select
            if (rd_req_out && rd_busy_in) begin
                rd_req_out <= 1'b0;
                rd_sel_out <= ~rd_sel_out;
            end
            if (rd_valid_in) begin
                mem[rd_addr_in] <= rd_data_in;
            end
            if (rd_last_in) begin
                done_out <= 1'b1;
            end
        end
    end
endmodule // smel_host_model

`default_nettype wire

/* File: tb_smel_log_builder.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_smel_log_builder;
    import smel_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_wr = 1'b0;
    smel_tf_t cmd_tf = '0;
    logic [31:0] ts = '0;
    smel_dev_state_t dstate = SMEL_ST_UNKNOWN;
    logic err_evt = 1'b0;
    smel_tf_t err_tf = '0;
    logic fault = 1'b0;
    logic [15:0] poh = '0;
    logic st_entry = 1'b0;
    logic go = 1'b0;
    logic sel = 1'b0;
    logic rd_req, rd_sel, rd_busy, rd_valid, rd_last, done;
    logic [7:0] rd_data;
    logic [8:0] rd_addr;
    logic [2:0] err_idx_o;
    logic [15:0] err_cnt_o;
    logic [4:0] st_idx_o;
    smel_cmd_snap_t hist [5];
    smel_err_rec_t rec [5];
    logic [3:0] last_st;
    logic [2:0] r_idx;
    logic [15:0] r_cnt;
    logic [4:0] r_st;
    logic [7:0] ex [512];
    int err_count = 0;
    int n_checks = 0;

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    smel_log_builder smel_log_builder_inst (
        .clk_in(clk_in), .rst_in(rst_in), .cmd_wr_in(cmd_wr), .cmd_tf_in(cmd_tf),
        .ts_in(ts), .dev_state_in(dstate), .err_evt_in(err_evt), .err_tf_in(err_tf),
        .err_dev_fault_in(fault), .poh_hours_in(poh), .st_entry_in(st_entry),
        .rd_req_in(rd_req), .rd_sel_st_in(rd_sel), .rd_busy_out(rd_busy),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data), .rd_addr_out(rd_addr),
        .rd_last_out(rd_last), .err_index_out(err_idx_o), .err_count_out(err_cnt_o),
        .st_index_out(st_idx_o)
    );

    smel_host_model smel_host_model_inst (
        .clk_in(clk_in), .rst_in(rst_in), .go_in(go), .sel_in(sel),
        .rd_busy_in(rd_busy), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
        .rd_addr_in(rd_addr), .rd_last_in(rd_last), .rd_req_out(rd_req),
        .rd_sel_out(rd_sel), .done_out(done)
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic do_cmd(input smel_tf_t tf, input logic [31:0] t, input smel_dev_state_t s);
        @(posedge clk_in);
        cmd_wr <= 1'b1;
        cmd_tf <= tf;
        ts <= t;
        dstate <= s;
        @(posedge clk_in);
        cmd_wr <= 1'b0;
        for (int i = 4; i > 0; i--) begin
            hist[i] = hist[i-1];
        end
        hist[0] = {tf, t};
        last_st = s;
    endtask

    // n back-to-back error events with the same completion bytes
    task automatic do_err(input smel_tf_t tf, input logic f, input logic [15:0] h, input int n);
        @(posedge clk_in);
        err_evt <= 1'b1;
        err_tf <= tf;
        fault <= f;
        poh <= h;
        repeat (n) begin
            @(posedge clk_in);
            r_idx = (r_idx == 3'h5) ? 3'h1 : r_idx + 3'h1;
            for (int s = 0; s < 5; s++) begin
                rec[r_idx-1].cmds[s] = hist[4-s];
            end
            rec[r_idx-1].tf = tf;
            rec[r_idx-1].state = {4'h0, last_st};
            rec[r_idx-1].poh = h;
            if (f && r_cnt != 16'hFFFF) begin
                r_cnt++;
            end
        end
        err_evt <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        chk("err_index", {29'h0, err_idx_o}, {29'h0, r_idx});
        chk("err_count", {16'h0, err_cnt_o}, {16'h0, r_cnt});
    endtask

    task automatic put_tf(input int b, input smel_tf_t tf);
        for (int i = 0; i < 8; i++) begin
            ex[b+i] = tf[63-8*i -: 8];
        end
    endtask

    // builds the expected sector, streams the real one and compares all bytes
    task automatic read_chk(input logic s);
        logic [7:0] sum;
        int b;
        int nv = 0;
        int nb = 0;
        for (int i = 0; i < 512; i++) begin
            ex[i] = 8'h00;
        end
        ex[0] = 8'h01;
        if (s) begin
            ex[508] = {3'h0, r_st};
        end else begin
            ex[1] = {5'h0, r_idx};
            for (int k = 0; k < 5; k++) begin
                b = 2 + 90 * k;
                for (int c = 0; c < 5; c++) begin
                    put_tf(b + 12 * c, rec[k].cmds[c].tf);
                    for (int i = 0; i < 4; i++) begin
                        ex[b+12*c+8+i] = rec[k].cmds[c].ts[8*i +: 8];
                    end
                end
                put_tf(b + 60, rec[k].tf);
                ex[b+87] = rec[k].state;
                ex[b+88] = rec[k].poh[7:0];
                ex[b+89] = rec[k].poh[15:8];
            end
            ex[452] = r_cnt[7:0];
            ex[453] = r_cnt[15:8];
        end
        sum = 8'h00;
        for (int i = 0; i < 511; i++) begin
            sum += ex[i];
        end
        ex[511] = -sum;
        @(posedge clk_in);
        go <= 1'b1;
        sel <= s;
        @(posedge clk_in);
        go <= 1'b0;
        // let the model clear done from the previous sector first
        @(posedge clk_in);
        for (int i = 0; done !== 1'b1; i++) begin
            if (i == 600) begin
                err_count++;
                summarize();
            end
            @(posedge clk_in);
            #1;
            nv += int'(rd_valid);
            nb += int'(rd_busy);
        end
        #1;
        for (int i = 0; i < 512; i++) begin
            chk($sformatf("sector%0d_byte%0d", s, i), {24'h0, smel_host_model_inst.mem[i]},
                {24'h0, ex[i]});
        end
        // busy drops with byte 511, so the window from the first stream edge sees 511
        chk("valid_bytes", 32'(nv), 32'h00000200);
        chk("busy_cycles", 32'(nb), 32'h000001FF);
        chk("busy_after", {31'h0, rd_busy}, 32'h00000000);
    endtask

    task automatic t_selftest();
        for (int k = 1; k <= 22; k++) begin
            @(posedge clk_in);
            st_entry <= 1'b1;
            @(posedge clk_in);
            st_entry <= 1'b0;
            r_st = (r_st == 5'h15) ? 5'h01 : r_st + 5'h01;
            repeat (2) @(posedge clk_in);
            #1;
            chk("st_index", {27'h0, st_idx_o}, {27'h0, r_st});
            if (k == 21) begin
                read_chk(1'b1);
            end
        end
        read_chk(1'b1);
    endtask

    task automatic t_errors();
        do_cmd(64'h1122334455667788, 32'hA1B2C3D4, SMEL_ST_ACTIVE);
        do_cmd(64'h99AABBCCDDEEFF00, 32'h01020304, SMEL_ST_STANDBY);
        do_err(64'h0F1E2D3C4B5A6978, 1'b1, 16'h1234, 1);
        do_cmd(64'h5A5A5A5A5A5A5A5A, 32'hCAFE0001, SMEL_ST_SLEEP);
        do_err(64'h0404040404040404, 1'b0, 16'h1235, 1);
        read_chk(1'b0);
        // wrap past the fifth entry, cycling every state code
        for (int k = 0; k < 6; k++) begin
            do_cmd(64'h0102030405060708 + 64'(k) * 64'h1111111111111111, 32'(k) + 32'h00010000,
                smel_dev_state_t'(4'(k % 5)));
            do_err(64'hF0E0D0C0B0A09080 - 64'(k), 1'b1, 16'h2000 + 16'(k), 1);
        end
        read_chk(1'b0);
    endtask

    initial begin
        for (int i = 0; i < 5; i++) begin
            hist[i] = '0;
            rec[i] = '0;
        end
        last_st = 4'h0;
        r_idx = 3'h0;
        r_cnt = 16'h0000;
        r_st = 5'h00;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk("reset_outputs", {8'h00, err_idx_o, err_cnt_o, st_idx_o}, 32'h0);
        read_chk(1'b0);
        read_chk(1'b1);
        t_errors();
        t_selftest();
        // drive the count to its ceiling and two events beyond it
        do_err(64'h0B0B0B0B0B0B0B0B, 1'b1, 16'hFFFE, 65537 - int'(r_cnt));
        read_chk(1'b0);
        summarize();
    end
endmodule // tb_smel_log_builder

`default_nettype wire
